/* common/sba_pkg.sv */
// Shared definitions for the two-master shared bus arbiter.
// Assumes one system clock; every request comes from logic on that clock.
package sba_pkg;

	// Address spaces carried with each request.
	localparam logic [1:0] SPACE_X = 2'h0;
	localparam logic [1:0] SPACE_Y = 2'h1;
	localparam logic [1:0] SPACE_P = 2'h2;

	// Arbitration method codes; code 3 behaves as round-robin.
	localparam logic [1:0] METHOD_M0_FIRST = 2'h0;
	localparam logic [1:0] METHOD_M1_FIRST = 2'h1;
	localparam logic [1:0] METHOD_ROUND_ROBIN = 2'h2;

	// Endpoint codes.
	localparam logic [1:0] EP_SHM = 2'h0;
	localparam logic [1:0] EP_PBUS = 2'h1;
	localparam logic [1:0] EP_EXT = 2'h2;

	// Address decode.
	localparam logic [23:0] SHM_LO = 24'h030000;
	localparam logic [23:0] SHM_HI = 24'h37FFFF;
	localparam logic [23:0] PBUS_LO = 24'hFFF000;
	localparam int BANK_LSB = 12;

	// Wait-state figures and reset values.
	localparam logic [3:0] SHM_P_WAIT = 4'h1;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [11:0] BANK_RST = 12'h000;

	// One access request from a shared bus master.
	typedef struct packed {
		logic valid;
		logic write;
		logic rmw;
		logic dma;
		logic cont;
		logic [1:0] space;
		logic [23:0] addr;
		logic [3:0] pws;
	} sba_req_s;

	// Answer to one master.
	typedef struct packed {
		logic ack;
		logic stall;
	} sba_rsp_s;

	// Whole state of the arbiter.
	typedef struct packed {
		logic [2:0] rr_flag;
		logic [1:0] act;
		logic [1:0][3:0] cnt;
		logic [1:0][1:0] act_ep;
		logic [1:0][11:0] act_bank;
		logic [1:0] ack;
		logic [1:0] stall;
		logic [2:0] lock_v;
		logic [2:0] lock_m;
		logic [11:0] lock_bank;
		logic [2:0] hold_v;
		logic [2:0] hold_m;
		logic [2:0] tail;
		logic [3:0] pcnt;
		logic wr_last;
		logic pbusy;
	} sba_state_s;

endpackage

/* design/sba_arbiter.sv */
// Arbiter between two shared bus masters for shared memory banks, the
// shared peripheral bus and external memory.
// Assumes requests, wait-state figures and the method select come from
// logic on MCLK, and that a master holds its request until ACK.
//
// What this block does
// - Method select: master 0, master 1, round-robin.
// - Fixed method: priority master wins contention unless the other master holds a reservation.
// - Round-robin: master 0 first, then alternate.
// - Uncontended access resets alternation to master 0.
// - One turn-flag bit per endpoint (three in all) follows the round-robin table.
// - RMW reserves next access for same master.
// - DMA continuous run blocks other until one cycle after.
// - Shared memory ignores DMA continuous, keeps RMW locks.
// - Shared memory decoded at 0x030000 to 0x37FFFF.
// - Different banks run together with zero waits.
// - Same bank: loser waits, nothing lost.
// - Core P-space shared memory access adds one wait.
// - Peripheral write acks at once, bus stays busy.
// - Access after waited write stalls those waits.
// - Read right after write gets one wait.
// - Peripheral reads zero waits besides peripheral/arbitration.
// - Arbitrate only when both hit same endpoint.
// - Arbitration itself adds no cycles.
// - Data answers follow address grant order.
`timescale 1ns/1ns
`default_nettype none

module sba_arbiter
(
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RST_N,
	// Method select from chip configuration.
	input wire logic [1:0] ARBITRATION_METHOD_SELECT,
	// Requests of both masters.
	input wire sba_pkg::sba_req_s M0_REQ,
	input wire sba_pkg::sba_req_s M1_REQ,
	// Answers to both masters.
	output sba_pkg::sba_rsp_s M0_RSP,
	output sba_pkg::sba_rsp_s M1_RSP,
	// Peripheral bus occupancy.
	output logic PBUS_BUSY
);

	// Endpoint decode, used for both masters.
	function automatic logic [1:0] to_ep(input logic [23:0] a);
		logic [1:0] e;
		e = sba_pkg::EP_EXT;
		if (a >= sba_pkg::SHM_LO && a <= sba_pkg::SHM_HI)
			e = sba_pkg::EP_SHM;
		else if (a >= sba_pkg::PBUS_LO)
			e = sba_pkg::EP_PBUS;
		return e;
	endfunction

	// Contention winner: returns 1 when master 1 wins.
	function automatic logic pick_m1(input logic [1:0] meth,
		input logic flag);
		logic w;
		w = 1'b0;
		if (meth == sba_pkg::METHOD_M0_FIRST)
			w = 1'b0;
		else if (meth == sba_pkg::METHOD_M1_FIRST)
			w = 1'b1;
		else
			w = flag;
		return w;
	endfunction

	sba_pkg::sba_state_s s_reg;
	sba_pkg::sba_state_s s_next;
	sba_pkg::sba_req_s req [2];
	logic [1:0] ep [2];
	logic [11:0] bank [2];
	logic [1:0] elig;
	logic [1:0] want;
	logic [1:0] take;
	logic contend;
	logic win1;
	logic [3:0] wait_n [2];
	logic rr_mode;

	// Decode of each request; a master in a waited access is not re-taken.
	always_comb
	begin
		req[0] = M0_REQ;
		req[1] = M1_REQ;
		for (int m = 0; m < 2; m++)
		begin
			ep[m] = to_ep(req[m].addr);
			bank[m] = req[m].addr[sba_pkg::BANK_LSB +: 12];
			elig[m] = req[m].valid & ~s_reg.act[m];
		end
	end

	// Blocking terms: reservations, busy banks and a busy peripheral bus.
	// A reserved endpoint never stalls its owner, only the other master.
	always_comb
	begin
		for (int m = 0; m < 2; m++)
		begin
			logic blk;
			logic o;
			logic [1:0] e;
			blk = 1'b0;
			o = (m == 0);
			e = ep[m];
			if (s_reg.lock_v[e] && s_reg.lock_m[e] != m[0] &&
				(e != sba_pkg::EP_SHM || s_reg.lock_bank == bank[m]))
				blk = 1'b1;
			if (e != sba_pkg::EP_SHM && (s_reg.hold_v[e] || s_reg.tail[e]) &&
				s_reg.hold_m[e] != m[0])
				blk = 1'b1;
			if (e == sba_pkg::EP_SHM && s_reg.act[o] &&
				s_reg.act_ep[o] == sba_pkg::EP_SHM &&
				s_reg.act_bank[o] == bank[m])
				blk = 1'b1;
			if (e == sba_pkg::EP_PBUS && s_reg.pcnt != sba_pkg::CNT_RST)
				blk = 1'b1;
			if (e == sba_pkg::EP_PBUS && s_reg.wr_last && !req[m].write)
				blk = 1'b1;
			want[m] = elig[m] & ~blk;
		end
	end

	// Contention exists only for the same endpoint, and for shared memory
	// only for the same bank; otherwise both go through in the same cycle.
	always_comb
	begin
		rr_mode = ARBITRATION_METHOD_SELECT[1];
		contend = want[0] & want[1] & (ep[0] == ep[1]) &
			(ep[0] != sba_pkg::EP_SHM || bank[0] == bank[1]);
		win1 = pick_m1(ARBITRATION_METHOD_SELECT, s_reg.rr_flag[ep[0]]);
		take[0] = want[0] & ~(contend & win1);
		take[1] = want[1] & ~(contend & ~win1);
		for (int m = 0; m < 2; m++)
		begin
			wait_n[m] = sba_pkg::CNT_RST;
			if (ep[m] == sba_pkg::EP_SHM && req[m].space == sba_pkg::SPACE_P &&
				!req[m].dma)
				wait_n[m] = sba_pkg::SHM_P_WAIT;
			else if (ep[m] == sba_pkg::EP_PBUS && !req[m].write)
				wait_n[m] = req[m].pws;
		end
	end

	// Next state.
	always_comb
	begin
		s_next = s_reg;
		s_next.ack = 2'h0;
		s_next.tail = 3'h0;
		s_next.wr_last = 1'b0;

		// Turn flags: toggled on a round-robin contention, cleared on any other access taken to that endpoint.
		for (int e = 0; e < 3; e++)
		begin
			if (contend && ep[0] == e[1:0] && rr_mode)
				s_next.rr_flag[e] = ~s_reg.rr_flag[e];
			else if ((take[0] && ep[0] == e[1:0]) ||
				(take[1] && ep[1] == e[1:0]))
				s_next.rr_flag[e] = 1'b0;
		end

		// Waited accesses count down; the answer comes in grant order
		// because each master has at most one access outstanding.
		for (int m = 0; m < 2; m++)
		begin
			if (s_reg.act[m])
			begin
				s_next.cnt[m] = s_reg.cnt[m] - 4'h1;
				if (s_reg.cnt[m] == 4'h1)
				begin
					s_next.act[m] = 1'b0;
					s_next.ack[m] = 1'b1;
				end
			end
		end

		// Release of a continuous-run hold once the holder stops; the
		// other master still waits through one tail cycle.
		for (int e = 1; e < 3; e++)
		begin
			logic h;
			h = s_reg.hold_m[e];
			if (s_reg.hold_v[e] && !s_reg.act[h] &&
				!(take[h] && ep[h] == e[1:0] && req[h].cont))
			begin
				s_next.hold_v[e] = 1'b0;
				s_next.tail[e] = 1'b1;
			end
		end

		// Peripheral bus occupancy counter.
		if (s_reg.pcnt != sba_pkg::CNT_RST)
			s_next.pcnt = s_reg.pcnt - 4'h1;

		// Effects of the accesses taken this cycle.
		for (int m = 0; m < 2; m++)
		begin
			if (take[m])
			begin
				if (wait_n[m] == sba_pkg::CNT_RST)
					s_next.ack[m] = 1'b1;
				else
				begin
					s_next.act[m] = 1'b1;
					s_next.cnt[m] = wait_n[m];
				end
				s_next.act_ep[m] = ep[m];
				s_next.act_bank[m] = bank[m];
				if (ep[m] == sba_pkg::EP_PBUS)
				begin
					s_next.pcnt = req[m].pws;
					s_next.wr_last = req[m].write;
				end
				if (s_reg.lock_v[ep[m]] && s_reg.lock_m[ep[m]] == m[0])
					s_next.lock_v[ep[m]] = 1'b0;
			end
		end
		for (int m = 0; m < 2; m++)
		begin
			if (take[m] && req[m].rmw)
			begin
				s_next.lock_v[ep[m]] = 1'b1;
				s_next.lock_m[ep[m]] = m[0];
				s_next.lock_bank = bank[m];
			end
			if (take[m] && req[m].dma && req[m].cont &&
				ep[m] != sba_pkg::EP_SHM)
			begin
				s_next.hold_v[ep[m]] = 1'b1;
				s_next.hold_m[ep[m]] = m[0];
				s_next.tail[ep[m]] = 1'b0;
			end
			s_next.stall[m] = elig[m] & ~take[m];
		end
		s_next.pbusy = (s_next.pcnt != sba_pkg::CNT_RST) |
			(s_next.act[0] & (s_next.act_ep[0] == sba_pkg::EP_PBUS)) |
			(s_next.act[1] & (s_next.act_ep[1] == sba_pkg::EP_PBUS));
	end

	// State register; reset clears flags, reservations and counters.
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			s_reg.rr_flag <= 3'h0;
			s_reg.act <= 2'h0;
			s_reg.cnt <= {sba_pkg::CNT_RST, sba_pkg::CNT_RST};
			s_reg.act_ep <= {sba_pkg::EP_SHM, sba_pkg::EP_SHM};
			s_reg.act_bank <= {sba_pkg::BANK_RST, sba_pkg::BANK_RST};
			s_reg.ack <= 2'h0;
			s_reg.stall <= 2'h0;
			s_reg.lock_v <= 3'h0;
			s_reg.lock_m <= 3'h0;
			s_reg.lock_bank <= sba_pkg::BANK_RST;
			s_reg.hold_v <= 3'h0;
			s_reg.hold_m <= 3'h0;
			s_reg.tail <= 3'h0;
			s_reg.pcnt <= sba_pkg::CNT_RST;
			s_reg.wr_last <= 1'b0;
			s_reg.pbusy <= 1'b0;
		end
		else
			s_reg <= s_next;
	end

	// Outputs straight from the state register.
	assign M0_RSP.ack = s_reg.ack[0];
	assign M0_RSP.stall = s_reg.stall[0];
	assign M1_RSP.ack = s_reg.ack[1];
	assign M1_RSP.stall = s_reg.stall[1];
	assign PBUS_BUSY = s_reg.pbusy;

endmodule // sba_arbiter

`default_nettype wire

/* verif/sba_arbiter_props.sv */
// Port checker for the two-master shared bus arbiter.
// Assumes each master holds its request until the ack pulse.
`timescale 1ns/1ns
`default_nettype none

module sba_arbiter_props
(
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RST_N,
	// Method, requests and answers.
	input wire logic [1:0] ARBITRATION_METHOD_SELECT,
	input wire sba_pkg::sba_req_s M0_REQ,
	input wire sba_pkg::sba_req_s M1_REQ,
	input wire sba_pkg::sba_rsp_s M0_RSP,
	input wire sba_pkg::sba_rsp_s M1_RSP,
	input wire logic PBUS_BUSY
);
	logic idle_reg;
	logic s0, s1, both, sb;

	// A fresh contention needs an idle cycle before it, else old locks count.
	always_ff @(posedge MCLK or negedge RST_N)
		if (!RST_N)
			idle_reg <= 1'b0;
		else
			idle_reg <= !M0_REQ.valid && !M1_REQ.valid;

	// Fresh X-space requests of both masters into shared memory.
	assign s0 = M0_REQ.addr inside {[sba_pkg::SHM_LO:sba_pkg::SHM_HI]};
	assign s1 = M1_REQ.addr inside {[sba_pkg::SHM_LO:sba_pkg::SHM_HI]};
	assign both = idle_reg && M0_REQ.valid && M1_REQ.valid && s0 && s1
		&& M0_REQ.space == 2'h0 && M1_REQ.space == 2'h0;
	assign sb = M0_REQ.addr[23:12] == M1_REQ.addr[23:12];

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	a_m0_ack_cause: assert property (M0_RSP.ack |-> $past(M0_REQ.valid))
		else $error("m0 ack without request");
	a_m1_ack_cause: assert property (M1_RSP.ack |-> $past(M1_REQ.valid))
		else $error("m1 ack without request");
	a_stall_cause: assert property (M1_RSP.stall |-> $past(M1_REQ.valid) && !M1_RSP.ack)
		else $error("m1 stall without request");
	a_fix_m0: assert property (both && sb && ARBITRATION_METHOD_SELECT == 2'h0 |=> M0_RSP.ack && M1_RSP.stall)
		else $error("master 0 priority broken");
	a_fix_m1: assert property (both && sb && ARBITRATION_METHOD_SELECT == 2'h1 |=> M1_RSP.ack && M0_RSP.stall)
		else $error("master 1 priority broken");
	a_rr_first: assert property (both && sb && ARBITRATION_METHOD_SELECT[1] |=> M0_RSP.ack ##1 M1_RSP.ack)
		else $error("round robin first grant wrong");
	a_bank_split: assert property (both && !sb |=> M0_RSP.ack && M1_RSP.ack)
		else $error("different banks delayed");
	a_p_wait: assert property (idle_reg && M0_REQ.valid && !M1_REQ.valid && s0 && M0_REQ.space == 2'h2 && !M0_REQ.dma |=> !M0_RSP.ack ##1 M0_RSP.ack)
		else $error("P space wait wrong");
	a_pw_fire: assert property (idle_reg && M0_REQ.valid && M0_REQ.write && M0_REQ.addr >= sba_pkg::PBUS_LO && !M1_REQ.valid && !PBUS_BUSY |=> M0_RSP.ack)
		else $error("peripheral write not immediate");
endmodule // sba_arbiter_props

bind sba_arbiter sba_arbiter_props u_props (.MCLK(MCLK), .RST_N(RST_N),
	.ARBITRATION_METHOD_SELECT(ARBITRATION_METHOD_SELECT), .M0_REQ(M0_REQ),
	.M1_REQ(M1_REQ), .M0_RSP(M0_RSP), .M1_RSP(M1_RSP), .PBUS_BUSY(PBUS_BUSY));

`default_nettype wire

/* verif/sba_master_model.sv */
// Shared bus master model: one core or DMA request held until ack.
// Assumes the arbiter acks with a one-cycle registered pulse.
`timescale 1ns/1ns
`default_nettype none

module sba_master_model
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Bench control and latency report.
	input wire logic go,
	input wire sba_pkg::sba_req_s r,
	output logic [31:0] lat,
	output logic done,
	// Shared bus side.
	input wire sba_pkg::sba_rsp_s rsp,
	output sba_pkg::sba_req_s req
);
	// Moves on the falling edge so the arbiter samples settled inputs.
	always @(negedge clk or negedge rst_n)
		if (!rst_n)
		begin
			req <= '0;
			lat <= 32'h0;
			done <= 1'b1;
		end
		else if (go)
		begin
			req <= r;
			lat <= 32'h0;
			done <= !r.valid;
		end
		else if (req.valid)
		begin
			lat <= lat + 32'h1;
			if (rsp.ack)
			begin
				// Released fields flip so stale values are never reused.
				// One assignment keeps a single write per time step.
				req <= {1'b0, ~req[36:0]};
				done <= 1'b1;
			end
		end
endmodule // sba_master_model

`default_nettype wire

/* verif/sba_arbiter_tb.sv */
// Testbench for the shared bus arbiter with two master models.
// Assumes the latencies of the arbiter hand-over timing.
`timescale 1ns/1ns
`default_nettype none

module sba_arbiter_tb;
	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic [1:0] sel = 2'h0;
	logic go0 = 1'b0;
	logic go1 = 1'b0;
	sba_pkg::sba_req_s r0 = '0;
	sba_pkg::sba_req_s r1 = '0;
	sba_pkg::sba_req_s q0, q1, x0, x1, xb, nil;
	sba_pkg::sba_rsp_s p0, p1;
	logic busy, d0, d1;
	logic [31:0] l0, l1;
	int n_fail = 0;
	int comparisons = 0;

	// Free-running 50 MHz clock.
	always #10 MCLK = ~MCLK;

	sba_arbiter u_sba_arbiter (.MCLK(MCLK), .RST_N(RST_N),
		.ARBITRATION_METHOD_SELECT(sel), .M0_REQ(q0), .M1_REQ(q1),
		.M0_RSP(p0), .M1_RSP(p1), .PBUS_BUSY(busy));
	sba_master_model u_m0 (.clk(MCLK), .rst_n(RST_N), .go(go0), .r(r0),
		.lat(l0), .done(d0), .rsp(p0), .req(q0));
	sba_master_model u_m1 (.clk(MCLK), .rst_n(RST_N), .go(go1), .r(r1),
		.lat(l1), .done(d1), .rsp(p1), .req(q1));

	function automatic sba_pkg::sba_req_s mk(logic w, logic dm,
		logic [1:0] sp, logic [23:0] a, logic [3:0] ws);
		mk = {1'b1, w, 1'b0, dm, 1'b0, sp, a, ws};
	endfunction

	task automatic finish_test();
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD %s exp %0d got %0d", n, e, s);
		end
	endtask

	// Starts both masters together and compares their ack latencies.
	task automatic run(input logic [1:0] m, input sba_pkg::sba_req_s a, b,
		input int e0, e1);
		int k;
		@(negedge MCLK);
		sel <= m;
		r0 <= a;
		r1 <= b;
		go0 <= 1'b1;
		go1 <= 1'b1;
		@(negedge MCLK);
		go0 <= 1'b0;
		go1 <= 1'b0;
		k = 0;
		do
		begin
			@(posedge MCLK);
			k++;
		end
		while (k < 40 && !(d0 && d1));
		if (k == 40)
		begin
			n_fail++;
			finish_test();
		end
		chk("lat0", l0, e0);
		chk("lat1", l1, e1);
	endtask

	task automatic t_fixed();
		run(2'h0, x0, x1, 1, 2);
		run(2'h1, x0, x1, 2, 1);
	endtask

	task automatic t_rr();
		run(2'h2, x0, x1, 1, 2);
		run(2'h2, nil, x1, 0, 1);
		run(2'h3, x0, x1, 1, 2);
	endtask

	task automatic t_paths();
		run(2'h0, x0, xb, 1, 1);
		run(2'h1, x0, mk(0, 0, 2'h1, 24'hFFF010, 4'h0), 1, 1);
		run(2'h0, mk(0, 0, 2'h2, 24'h030000, 4'h0), nil, 2, 0);
		run(2'h0, mk(0, 1, 2'h2, 24'h030000, 4'h0), nil, 1, 0);
	endtask

	task automatic t_pbus();
		run(2'h0, mk(1, 0, 2'h0, 24'hFFF020, 4'h3), nil, 1, 0);
		@(negedge MCLK);
		chk("busy", busy, 32'h1);
		repeat (3) @(negedge MCLK);
		chk("idle", busy, 32'h0);
		run(2'h0, mk(1, 0, 2'h0, 24'hFFF020, 4'h3), mk(0, 0, 2'h0, 24'hFFF030, 4'h0), 1, 5);
		repeat (4) @(negedge MCLK);
		run(2'h0, mk(1, 0, 2'h0, 24'hFFF020, 4'h0), mk(0, 0, 2'h0, 24'hFFF030, 4'h0), 1, 3);
		run(2'h0, mk(0, 0, 2'h0, 24'hFFF030, 4'h2), nil, 3, 0);
	endtask

	// Reservations: a locked endpoint beats priority, a DMA run holds off.
	task automatic t_hold();
		sba_pkg::sba_req_s a, b;
		a = mk(0, 0, 2'h0, 24'hFFF040, 4'h0);
		a.rmw = 1'b1;
		b = mk(0, 0, 2'h0, 24'hFFF050, 4'h0);
		run(2'h1, a, nil, 1, 0);
		run(2'h1, mk(0, 0, 2'h0, 24'hFFF040, 4'h0), b, 1, 2);
		a = mk(0, 1, 2'h0, 24'hFFF040, 4'h0);
		a.cont = 1'b1;
		run(2'h0, a, b, 1, 4);
	endtask

	// Reset, then every scenario in turn.
	initial
	begin
		x0 = mk(0, 0, 2'h0, 24'h030000, 4'h0);
		x1 = mk(0, 0, 2'h0, 24'h030010, 4'h0);
		xb = mk(0, 0, 2'h0, 24'h031000, 4'h0);
		nil = '0;
		repeat (10) @(negedge MCLK);
		RST_N <= 1'b1;
		chk("rst", {p0, p1, busy}, 32'h0);
		t_fixed();
		t_rr();
		t_paths();
		t_pbus();
		t_hold();
		finish_test();
	end
endmodule // sba_arbiter_tb

`default_nettype wire
